// file: design/ubc_break_cond.v
// Break-condition registers and bus-cycle comparators for channels 6 and 7, with an APB slave.
//
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "ubc_defs.vh"

// How it works
// - Channel 6 address register, cleared at reset.
// - Bus-select picks C bus or I bus address.
// - C fetch compares fetch bus; I compares internal.
// - C data access compares memory access bus.
// - Mask bit one excludes that address bit.
// - Channel 6 mask register, cleared at reset.
// - Channel 6 cycle register, 16 bits, cleared.
// - Bit 13 suppresses the break interrupt request.
// - Bits 15,14,12,11 read zero, ignore writes.
// - Master field gates I-bus masters; C is CPU.
// - Bus-select: off, C, I, C.
// - Access type: off, fetch, data, either.
// - Direction: off, read, write, both.
// - Size: any, byte, word, longword.
// - Channel 7 address register, own bus select.
// - Channel 7 mask register, same mask meaning.
// - Channel 7 cycle register, same layout as 6.
// - C bus match sets flag; software writes zero.
module ubc_break_cond (
  // Clock and reset
  input  wire        clk_sys_i,
  input  wire        resetn_i,
  // APB slave
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [11:0] paddr_i,
  input  wire [31:0] pwdata_i,
  output wire        pready_o,
  output wire        pslverr_o,
  output reg  [31:0] prdata_o,
  // C bus, fetch side
  input  wire        fetch_valid_i,
  input  wire [31:0] fetch_address_bus_i,
  input  wire [1:0]  fetch_size_i,
  // C bus, data side
  input  wire        mem_valid_i,
  input  wire [31:0] memory_access_address_bus_i,
  input  wire        mem_write_i,
  input  wire [1:0]  mem_size_i,
  // I bus
  input  wire        ibus_valid_i,
  input  wire [31:0] internal_address_bus_i,
  input  wire        ibus_write_i,
  input  wire        ibus_fetch_i,
  input  wire [1:0]  ibus_size_i,
  input  wire [1:0]  ibus_master_i,
  // Break results, channel 6 in bit 0 and channel 7 in bit 1
  output reg  [1:0]  break_match_o,
  output reg  [1:0]  break_irq_req_o,
  output wire [1:0]  cbus_match_flag_o
);

  // ****************************************************************
  // Register file
  // ****************************************************************
  reg  [31:0] break_address_ch6;
  reg  [31:0] break_address_mask_ch6;
  reg  [15:0] break_cycle_condition_ch6;
  reg  [31:0] break_address_ch7;
  reg  [31:0] break_address_mask_ch7;
  reg  [15:0] break_cycle_condition_ch7;
  reg  [1:0]  cbus_match_flag;

  wire        wr_en;
  wire        addr_hit;
  wire [1:0]  cbus_hit;
  wire [1:0]  any_hit;
  wire [1:0]  irq_dis;

  // Zero wait states: the access phase always completes in one cycle.
  assign pready_o  = 1'b1;
  assign addr_hit  = (paddr_i == `UBC_OFS_ADDR6) || (paddr_i == `UBC_OFS_MASK6) ||
                     (paddr_i == `UBC_OFS_COND6) || (paddr_i == `UBC_OFS_ADDR7) ||
                     (paddr_i == `UBC_OFS_MASK7) || (paddr_i == `UBC_OFS_COND7) ||
                     (paddr_i == `UBC_OFS_FLAGS);
  assign pslverr_o = psel_i & penable_i & ~addr_hit;
  assign wr_en     = psel_i & penable_i & pwrite_i;
  assign cbus_match_flag_o = cbus_match_flag;

  // Sleep mode is not seen here; registers keep contents until reset.
  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      break_address_ch6         <= `UBC_RST_ADDR;
      break_address_mask_ch6    <= `UBC_RST_MASK;
      break_cycle_condition_ch6 <= `UBC_RST_COND;
      break_address_ch7         <= `UBC_RST_ADDR;
      break_address_mask_ch7    <= `UBC_RST_MASK;
      break_cycle_condition_ch7 <= `UBC_RST_COND;
    end else if (wr_en) begin
      case (paddr_i)
        `UBC_OFS_ADDR6: begin
          break_address_ch6 <= pwdata_i;
        end
        `UBC_OFS_MASK6: begin
          break_address_mask_ch6 <= pwdata_i;
        end
        `UBC_OFS_COND6: begin
          break_cycle_condition_ch6 <= pwdata_i[15:0] & `UBC_COND_WMASK;
        end
        `UBC_OFS_ADDR7: begin
          break_address_ch7 <= pwdata_i;
        end
        `UBC_OFS_MASK7: begin
          break_address_mask_ch7 <= pwdata_i;
        end
        `UBC_OFS_COND7: begin
          break_cycle_condition_ch7 <= pwdata_i[15:0] & `UBC_COND_WMASK;
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************************************
  // Match flags
  // ****************************************************************
  // A write of 0 clears a flag, a write of 1 keeps it; a hit in the same cycle wins.
  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cbus_match_flag <= 2'h0;
    end else if (wr_en && (paddr_i == `UBC_OFS_FLAGS)) begin
      cbus_match_flag <= (cbus_match_flag & pwdata_i[1:0]) | cbus_hit;
    end else begin
      cbus_match_flag <= cbus_match_flag | cbus_hit;
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prdata_o <= 32'h00000000;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      case (paddr_i)
        `UBC_OFS_ADDR6: begin
          prdata_o <= break_address_ch6;
        end
        `UBC_OFS_MASK6: begin
          prdata_o <= break_address_mask_ch6;
        end
        `UBC_OFS_COND6: begin
          prdata_o <= {16'h0000, break_cycle_condition_ch6};
        end
        `UBC_OFS_ADDR7: begin
          prdata_o <= break_address_ch7;
        end
        `UBC_OFS_MASK7: begin
          prdata_o <= break_address_mask_ch7;
        end
        `UBC_OFS_COND7: begin
          prdata_o <= {16'h0000, break_cycle_condition_ch7};
        end
        `UBC_OFS_FLAGS: begin
          prdata_o <= {30'h00000000, cbus_match_flag};
        end
        default: begin
          prdata_o <= 32'h00000000;
        end
      endcase
    end
  end

  // ****************************************************************
  // Per-channel comparators
  // ****************************************************************
  // The fetch address LSB is compared as stored, so a set LSB hits only a fetch whose address LSB is also set.
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
      wire [31:0] brk_addr;
      wire [31:0] brk_mask;
      wire [15:0] cond;
      wire [2:0]  ibus_master_select;
      wire [1:0]  bus_side_select;
      wire [1:0]  fetch_or_data_select;
      wire [1:0]  direction_select;
      wire [1:0]  operand_size_select;
      wire        all_on;
      wire        sel_ibus;
      wire        fetch_hit;
      wire        data_hit;
      wire        ibus_hit;
      wire        ibus_mst_ok;

      assign brk_addr = (ch == 0) ? break_address_ch6 : break_address_ch7;
      assign brk_mask = (ch == 0) ? break_address_mask_ch6 : break_address_mask_ch7;
      assign cond     = (ch == 0) ? break_cycle_condition_ch6 : break_cycle_condition_ch7;
      assign ibus_master_select   = cond[`UBC_MST_HI:`UBC_MST_LO];
      assign bus_side_select      = cond[`UBC_BUS_HI:`UBC_BUS_LO];
      assign fetch_or_data_select = cond[`UBC_FD_HI:`UBC_FD_LO];
      assign direction_select     = cond[`UBC_DIR_HI:`UBC_DIR_LO];
      assign operand_size_select  = cond[`UBC_SZ_HI:`UBC_SZ_LO];

      assign all_on = (bus_side_select != `UBC_SEL_OFF) &&
                      (fetch_or_data_select != `UBC_SEL_OFF) &&
                      (direction_select != `UBC_SEL_OFF);
      assign sel_ibus = (bus_side_select == `UBC_BUS_IBUS);

      // Fetches are reads on the C bus, issued by the CPU only.
      assign fetch_hit = fetch_valid_i && fetch_or_data_select[0] && direction_select[0] &&
                         (((fetch_address_bus_i ^ brk_addr) & ~brk_mask) == 32'h00000000) &&
                         ((operand_size_select == `UBC_SEL_OFF) ||
                          (operand_size_select == fetch_size_i));
      assign data_hit  = mem_valid_i && fetch_or_data_select[1] &&
                         (mem_write_i ? direction_select[1] : direction_select[0]) &&
                         (((memory_access_address_bus_i ^ brk_addr) & ~brk_mask) ==
                          32'h00000000) &&
                         ((operand_size_select == `UBC_SEL_OFF) ||
                          (operand_size_select == mem_size_i));
      assign ibus_mst_ok = ((ibus_master_i == `UBC_MST_CPU)  && ibus_master_select[0]) ||
                           ((ibus_master_i == `UBC_MST_DMA)  && ibus_master_select[1]) ||
                           ((ibus_master_i == `UBC_MST_ADMA) && ibus_master_select[2]);
      assign ibus_hit  = ibus_valid_i && ibus_mst_ok &&
                         (ibus_fetch_i ? fetch_or_data_select[0] : fetch_or_data_select[1]) &&
                         (ibus_write_i ? direction_select[1] : direction_select[0]) &&
                         (((internal_address_bus_i ^ brk_addr) & ~brk_mask) == 32'h00000000) &&
                         ((operand_size_select == `UBC_SEL_OFF) ||
                          (operand_size_select == ibus_size_i));

      assign cbus_hit[ch] = all_on && !sel_ibus && (fetch_hit || data_hit);
      assign any_hit[ch]  = all_on && (sel_ibus ? ibus_hit : (fetch_hit || data_hit));
      assign irq_dis[ch]  = cond[`UBC_IRQ_DIS_BIT];
    end
  endgenerate

  // ****************************************************************
  // Registered results
  // ****************************************************************
  // Both channels share one process so that each result vector has a single driver.
  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      break_match_o   <= 2'h0;
      break_irq_req_o <= 2'h0;
    end else begin
      break_match_o   <= any_hit;
      break_irq_req_o <= any_hit & ~irq_dis;
    end
  end

endmodule
`default_nettype wire

// file: design/ubc_defs.vh
// Register offsets, field positions, reset values and access codes for the break-condition block.
`ifndef UBC_DEFS_VH
`define UBC_DEFS_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define UBC_OFS_ADDR6   12'h000
`define UBC_OFS_MASK6   12'h004
`define UBC_OFS_COND6   12'h008
`define UBC_OFS_ADDR7   12'h00C
`define UBC_OFS_MASK7   12'h010
`define UBC_OFS_COND7   12'h014
`define UBC_OFS_FLAGS   12'h018

// ****************************************************************
// Reset values
// ****************************************************************
`define UBC_RST_ADDR    32'h00000000
`define UBC_RST_MASK    32'h00000000
`define UBC_RST_COND    16'h0000

// ****************************************************************
// Cycle condition field layout
// ****************************************************************
`define UBC_COND_WMASK  16'h27FF
`define UBC_IRQ_DIS_BIT 13
`define UBC_MST_HI      10
`define UBC_MST_LO      8
`define UBC_BUS_HI      7
`define UBC_BUS_LO      6
`define UBC_FD_HI       5
`define UBC_FD_LO       4
`define UBC_DIR_HI      3
`define UBC_DIR_LO      2
`define UBC_SZ_HI       1
`define UBC_SZ_LO       0

// ****************************************************************
// Field encodings
// ****************************************************************
`define UBC_SEL_OFF     2'h0
`define UBC_BUS_IBUS    2'h2
`define UBC_SZ_BYTE     2'h1
`define UBC_SZ_WORD     2'h2
`define UBC_SZ_LONG     2'h3
`define UBC_MST_CPU     2'h0
`define UBC_MST_DMA     2'h1
`define UBC_MST_ADMA    2'h2

`endif

// file: verification/ubc_break_cond_properties.sv
// Port-level assertions for the break-condition block.
`timescale 1ns/100ps
`default_nettype none
module ubc_break_cond_properties (
  input wire logic clk_sys_i, resetn_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o,
  input wire logic fetch_valid_i, mem_valid_i, ibus_valid_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i, prdata_o,
  input wire logic [1:0]  break_match_o, break_irq_req_o, cbus_match_flag_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  wire logic acc = psel_i && penable_i;
  a_ready_high: assert property (pready_o) else $error("pready low");
  a_unmapped_err: assert property (acc |->
    pslverr_o == (paddr_i > 12'h018 || paddr_i[1:0] != 2'h0)) else $error("pslverr wrong");
  a_reserved_zero: assert property (acc && !pwrite_i && (paddr_i == 12'h008 ||
    paddr_i == 12'h014) |-> prdata_o[31:14] == 18'h0 && prdata_o[12:11] == 2'h0)
    else $error("reserved bits read nonzero");
  a_irq_gated: assert property ((break_irq_req_o & ~break_match_o) == 2'h0)
    else $error("request without match");
  a_match_pulse: assert property (!(fetch_valid_i || mem_valid_i || ibus_valid_i) |=>
    break_match_o == 2'h0) else $error("match without bus cycle");
  a_flag_set6: assert property ($rose(cbus_match_flag_o[0]) |->
    break_match_o[0] && $past(fetch_valid_i || mem_valid_i)) else $error("flag 6 set wrongly");
  a_flag_set7: assert property ($rose(cbus_match_flag_o[1]) |->
    break_match_o[1] && $past(fetch_valid_i || mem_valid_i)) else $error("flag 7 set wrongly");
  a_flag_clear: assert property ($fell(cbus_match_flag_o[0]) |->
    $past(acc && pwrite_i && paddr_i == 12'h018 && !pwdata_i[0])) else $error("flag 6 lost");
  a_reset_clear: assert property ($rose(resetn_i) |->
    break_match_o == 2'h0 && cbus_match_flag_o == 2'h0) else $error("outputs not cleared");
  cover property (break_match_o[0] && cbus_match_flag_o[0]);
  cover property (break_irq_req_o[1]);
  cover property ($fell(cbus_match_flag_o[1]));
endmodule
`default_nettype wire

// file: verification/ubc_bus_model.sv
// Partner model that drives one watched processor or DMA bus cycle at a time.
`timescale 1ns/100ps
`default_nettype none
module ubc_bus_model (
  input  wire logic        clk_i,
  output logic [2:0]  vld_o,
  output logic [31:0] fab_o, mab_o, iab_o,
  output logic        wr_o, ifetch_o,
  output logic [1:0]  sz_o, mst_o
);
  initial {vld_o, fab_o, mab_o, iab_o, wr_o, ifetch_o, sz_o, mst_o} = '0;
  // Idle buses show the inverted address, so a comparator on the wrong bus cannot hit.
  task automatic cycle(input logic [2:0] v, input logic [31:0] a, input logic w, f,
                       input logic [1:0] s, m);
    {vld_o, wr_o, ifetch_o, sz_o, mst_o} <= {v, w, f, s, m};
    fab_o <= v[0] ? a : ~a;
    mab_o <= v[1] ? a : ~a;
    iab_o <= v[2] ? a : ~a;
    @(posedge clk_i);
    {vld_o, fab_o, mab_o, iab_o} <= {3'h0, ~a, ~a, ~a};
  endtask
endmodule
`default_nettype wire

// file: verification/test_ubc_break_cond.sv
// Random and corner-case bench for the break-condition block.
`timescale 1ns/100ps
`default_nettype none
module test_ubc_break_cond;
  logic clk_sys_i = 1'b0, resetn_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h00000000;
  wire  logic        pready_o, pslverr_o, wr, ifetch;
  wire  logic [31:0] prdata_o, fab, memory_access_address_bus, internal_address_bus;
  wire  logic [2:0]  vld;
  wire  logic [1:0]  sz, mst, break_match_o, break_irq_req_o, cbus_match_flag_o;
  int          error_cnt = 0, compares = 0, cyc = 0, k;
  logic [31:0] rd, wd, a, r, ba [2], bm [2];
  logic [15:0] cc [2];
  logic [1:0]  fexp, hexp;
  logic        err;
  initial forever #20 clk_sys_i = ~clk_sys_i;
  ubc_break_cond i_ubc_break_cond (.*, .fetch_valid_i(vld[0]), .fetch_address_bus_i(fab),
    .fetch_size_i(sz), .mem_valid_i(vld[1]), .memory_access_address_bus_i(memory_access_address_bus),
    .mem_write_i(wr), .mem_size_i(sz), .ibus_valid_i(vld[2]), .internal_address_bus_i(internal_address_bus),
    .ibus_write_i(wr), .ibus_fetch_i(ifetch), .ibus_size_i(sz), .ibus_master_i(mst));
  ubc_bus_model i_ubc_bus_model (.clk_i(clk_sys_i), .vld_o(vld), .fab_o(fab), .mab_o(memory_access_address_bus),
    .iab_o(internal_address_bus), .wr_o(wr), .ifetch_o(ifetch), .sz_o(sz), .mst_o(mst));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    @(posedge clk_sys_i);
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'b10, w, ad, d};
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    @(posedge clk_sys_i);
    while (pready_o !== 1'b1) @(posedge clk_sys_i);
    rd = prdata_o;
    err = pslverr_o;
    {psel_i, penable_i} <= 2'b00;
  endtask
  function automatic logic hit(input logic [15:0] c, input logic [31:0] b, m, a, r,
                               input logic [2:0] v);
    c = c & 16'h27FF;
    return (c[6] ? v[0] || v[1] : c[7] && v[2] && c[8 + r[5:4]])
      && ((v[0] || v[2] && r[1]) ? c[4] : c[5]) && ((!v[0] && r[0]) ? c[3] : c[2])
      && (c[1:0] == 2'h0 || c[1:0] == r[3:2]) && ((a ^ b) & ~m) == 32'h0;
  endfunction
  task automatic check_zero(input string name);
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, 12'(4 * i), 32'h0);
      chk(rd, 32'h0);
      chk(err, i == 7);
    end
    $display("test %s done", name);
  endtask
  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt++;
      give_verdict();
    end
  end
  initial begin
    wd = $urandom(2);
    fexp = 2'h0;
    repeat (20) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    check_zero("reset values");
    for (int i = 0; i < 60; i++) begin
      wd = $urandom;
      apb(1'b1, 12'(4 * (i % 6)), wd);
      apb(1'b0, 12'(4 * (i % 6)), 32'h0);
      chk(rd, (i % 3 == 2) ? wd & 32'h000027FF : wd);
    end
    $display("test register access done");
    for (int i = 0; i < 400; i++) begin
      wd = $urandom;
      apb(1'b1, 12'h018, wd);
      fexp = fexp & wd[1:0];
      for (int ch = 0; ch < 2; ch++) begin
        cc[ch] = 16'($urandom);
        cc[ch][6] = cc[ch][6] | cc[ch][4];
        ba[ch] = $urandom & ~{31'h0, cc[ch][4]};
        bm[ch] = (i < 8) ? 32'h0 : $urandom & $urandom & $urandom;
        apb(1'b1, 12'(12 * ch), ba[ch]);
        apb(1'b1, 12'(12 * ch + 4), bm[ch]);
        apb(1'b1, 12'(12 * ch + 8), {16'h0, cc[ch]});
      end
      r = $urandom;
      k = r[7:6] % 3;
      a = (r[8] && r[9]) ? $urandom : ba[i % 2] ^ ($urandom & bm[i % 2]);
      hexp = {hit(cc[1], ba[1], bm[1], a, r, 3'h1 << k),
              hit(cc[0], ba[0], bm[0], a, r, 3'h1 << k)};
      i_ubc_bus_model.cycle(3'h1 << k, a, r[0], r[1], r[3:2], r[5:4]);
      fexp = fexp | (hexp & {2{k != 2}});
      #1;
      chk(break_match_o, hexp);
      chk(break_irq_req_o, hexp & ~{cc[1][13], cc[0][13]});
      chk(cbus_match_flag_o, fexp);
    end
    $display("test random matching done");
    @(posedge clk_sys_i);
    resetn_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    check_zero("second reset");
    give_verdict();
  end
endmodule
bind ubc_break_cond ubc_break_cond_properties i_ubc_break_cond_properties (.*);
`default_nettype wire
